// *** tbg_pkg.sv ***
package tbg_pkg;

   // Register map, byte addresses on the plain register port
   localparam logic [7:0]  ADDR_CTRL       = 8'h00;
   localparam logic [7:0]  ADDR_STAT       = 8'h04;

   // Control register fields
   localparam int unsigned CTRL_PRBS_BIT   = 0;
   localparam int unsigned CTRL_MODE_LSB   = 1;
   localparam int unsigned CTRL_ENC_BIT    = 4;
   localparam int unsigned CTRL_WIDE_BIT   = 5;
   localparam int unsigned CTRL_RESTART_BIT = 8;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0010;

   // Status register fields
   localparam int unsigned STAT_DONE_BIT   = 0;
   localparam int unsigned STAT_ERR_BIT    = 1;
   localparam int unsigned STAT_STATE_LSB  = 2;
   localparam int unsigned STAT_CNT_LSB    = 16;

   // Self-test pattern selection
   typedef enum logic [2:0] {
      TM_OFF  = 3'h0,
      TM_INCR = 3'h1,
      TM_HF   = 3'h2,
      TM_LF   = 3'h3,
      TM_MIX  = 3'h4
   } tbg_mode_t;

   // Verifier states, Gray along wait, hunt, check, done
   typedef enum logic [1:0] {
      VS_WAIT  = 2'h0,
      VS_HUNT  = 2'h1,
      VS_CHECK = 2'h3,
      VS_DONE  = 2'h2
   } tbg_vstate_t;

   // Eight-bit character values handed to the encoder
   localparam logic [7:0]  CH_K28_5        = 8'hBC;
   localparam logic [7:0]  CH_K27_7        = 8'hFB;
   localparam logic [7:0]  CH_K29_7        = 8'hFD;
   localparam logic [7:0]  CH_K28_7        = 8'hFC;
   localparam logic [7:0]  CH_D21_5        = 8'hB5;

   // Incremental sequence layout: comma, SOF, 256 data, 10 tail K chars
   localparam logic [8:0]  INC_SOF         = 9'h001;
   localparam logic [8:0]  INC_DATA0       = 9'h002;
   localparam logic [8:0]  INC_TAIL0       = 9'h102;
   localparam logic [8:0]  INC_LAST        = 9'h10B;
   localparam logic [4:0]  SOF_WINDOW      = 5'h1F;

   // PRBS sequence lengths and generator seed
   localparam logic [9:0]  PRBS8_LEN       = 10'h0FF;
   localparam logic [9:0]  PRBS10_LEN      = 10'h3FF;
   localparam logic [9:0]  PRBS_SEED       = 10'h001;

   // Word aligner patterns that the channel must be set up with
   localparam logic [15:0] ALIGN_8BIT      = 16'h40FF;
   localparam logic [9:0]  ALIGN_10BIT     = 10'h3FF;

   typedef struct packed {
      logic       k;
      logic [7:0] b;
   } tbg_sym_t;

   typedef struct packed {
      logic       enc_bypass;
      logic       k;
      logic [9:0] data;
   } tbg_tx_t;

   typedef struct packed {
      logic       sync;
      logic       k;
      logic [9:0] data;
   } tbg_rx_t;

   // One word step; 8-bit taps 8,7,5,3 and 10-bit taps 10,7
   function automatic logic [9:0] prbs_step(input logic [9:0] s,
                                            input logic       wide);
      logic [9:0] n;
      n = wide ? {s[8:0], s[9] ^ s[6]}
               : {2'b00, s[6:0], s[7] ^ s[6] ^ s[4] ^ s[2]};
      // Escape the all-zero lockup state
      if (n == 10'h000) begin
         n = PRBS_SEED;
      end
      return n;
   endfunction

   function automatic tbg_sym_t inc_symbol(input logic [8:0] idx);
      tbg_sym_t   s;
      logic [3:0] t;
      t   = 4'(idx - INC_TAIL0);
      s.k = 1'b1;
      s.b = CH_K28_5;
      if (idx == INC_SOF) begin
         s.b = CH_K27_7;
      end else if (idx >= INC_DATA0 && idx < INC_TAIL0) begin
         s.k = 1'b0;
         s.b = 8'(idx - INC_DATA0);
      end else if (idx >= INC_TAIL0) begin
         unique case (t)
            4'h0:    s.b = 8'h1C;
            4'h1:    s.b = 8'h3C;
            4'h2:    s.b = 8'h5C;
            4'h3:    s.b = 8'h7C;
            4'h4:    s.b = 8'h9C;
            4'h5:    s.b = 8'hDC;
            4'h6:    s.b = 8'hFC;
            4'h7:    s.b = 8'hF7;
            4'h8:    s.b = 8'hFE;
            default: s.b = CH_K29_7;
         endcase
      end
      return s;
   endfunction

endpackage

// *** tbg_bist.sv ***
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
module tbg_bist (
   input  wire logic              clk_sys_i,
   input  wire logic              resetn_i,
   input  wire logic [7:0]        reg_addr_i,
   input  wire logic [31:0]       reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic [31:0]            reg_rdata_o,
   input  wire logic              rx_digital_reset_i,
   output tbg_pkg::tbg_tx_t       tx_o,
   input  wire tbg_pkg::tbg_rx_t  rx_i,
   output logic                   rx_dec_bypass_o,
   output logic                   bist_done_o,
   output logic                   bist_err_o
);
   import tbg_pkg::*;

   logic        ctrl_prbs_q;
   tbg_mode_t   ctrl_mode_q;
   logic        ctrl_enc_q;
   logic        ctrl_wide_q;
   logic        restart_q;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;

   logic [9:0]  gen_lfsr_q;
   logic [9:0]  gen_lfsr_d;
   logic [8:0]  gen_idx_q;
   logic [8:0]  gen_idx_d;
   tbg_sym_t    gen_sym;
   tbg_tx_t     tx_d;
   tbg_tx_t     tx_q;

   tbg_vstate_t v_state_q;
   tbg_vstate_t v_state_d;
   logic [9:0]  v_exp_q;
   logic [9:0]  v_exp_d;
   logic [9:0]  v_cnt_q;
   logic [9:0]  v_cnt_d;
   logic [8:0]  v_idx_q;
   logic [8:0]  v_idx_d;
   logic        v_pass_q;
   logic        v_pass_d;
   logic        set_done;
   logic        set_err;
   logic        done_q;
   logic        err_q;
   logic        bypass_q;

   // Register port decode
   wire         wr_ctrl      = reg_wr_i && reg_addr_i == ADDR_CTRL;
   wire         rd_ctrl      = reg_rd_i && reg_addr_i == ADDR_CTRL;
   wire         rd_stat      = reg_rd_i && reg_addr_i == ADDR_STAT;
   wire         restart      = restart_q || rx_digital_reset_i;
   wire         enc_off      = !ctrl_enc_q;

   // Verifier selection and receive word views
   wire         v_prbs       = ctrl_prbs_q;
   wire         v_inc        = !ctrl_prbs_q && ctrl_mode_q == TM_INCR;
   wire  [9:0]  rx_word      = ctrl_wide_q ? rx_i.data
                                           : {2'b00, rx_i.data[7:0]};
   wire  [9:0]  prbs_total   = ctrl_wide_q ? PRBS10_LEN : PRBS8_LEN;
   wire         prbs_match   = rx_word == v_exp_q;
   wire         rx_is_sof    = rx_i.k && rx_i.data[7:0] == CH_K27_7;
   tbg_sym_t    exp_sym;
   assign       exp_sym      = inc_symbol(v_idx_q);
   wire         inc_match    = rx_i.k == exp_sym.k
                               && rx_i.data[7:0] == exp_sym.b;

   wire  [31:0] ctrl_view    = {23'h00_0000,
                                1'b0,
                                2'b00,
                                ctrl_wide_q,
                                ctrl_enc_q,
                                ctrl_mode_q,
                                ctrl_prbs_q};
   wire  [31:0] stat_view    = {6'h00,
                                v_cnt_q,
                                12'h000,
                                v_state_q,
                                err_q,
                                done_q};

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (rd_ctrl) begin
         rdata_d = ctrl_view;
      end else if (rd_stat) begin
         rdata_d = stat_view;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_prbs_q <= CTRL_RESET[CTRL_PRBS_BIT];
         ctrl_mode_q <= tbg_mode_t'(CTRL_RESET[CTRL_MODE_LSB +: 3]);
         ctrl_enc_q  <= CTRL_RESET[CTRL_ENC_BIT];
         ctrl_wide_q <= CTRL_RESET[CTRL_WIDE_BIT];
         restart_q   <= 1'b0;
         rdata_q     <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) begin
            ctrl_prbs_q <= reg_wdata_i[CTRL_PRBS_BIT];
            ctrl_mode_q <= tbg_mode_t'(reg_wdata_i[CTRL_MODE_LSB +: 3]);
            ctrl_enc_q  <= reg_wdata_i[CTRL_ENC_BIT];
            ctrl_wide_q <= reg_wdata_i[CTRL_WIDE_BIT];
         end
         restart_q <= wr_ctrl && reg_wdata_i[CTRL_RESTART_BIT];
         rdata_q   <= rdata_d;
      end
   end

   // Pattern generator; one symbol per clock
   always_comb begin
      gen_lfsr_d = gen_lfsr_q;
      gen_idx_d  = 9'h000;
      gen_sym    = '0;
      tx_d       = '0;
      tx_d.enc_bypass = ctrl_prbs_q || enc_off;
      if (ctrl_prbs_q) begin
         gen_lfsr_d = prbs_step(gen_lfsr_q, ctrl_wide_q);
         tx_d.data  = gen_lfsr_d;
      end else begin
         unique case (ctrl_mode_q)
            TM_INCR: begin
               gen_sym   = inc_symbol(gen_idx_q);
               gen_idx_d = (gen_idx_q == INC_LAST) ? 9'h000
                                                   : gen_idx_q + 9'h001;
            end
            TM_HF:   gen_sym = '{k: 1'b0, b: CH_D21_5};
            TM_LF:   gen_sym = '{k: 1'b1, b: CH_K28_7};
            TM_MIX:  gen_sym = '{k: 1'b1, b: CH_K28_5};
            // Off and unused codes send idle zeros
            default: gen_sym = '0;
         endcase
         tx_d.k    = gen_sym.k;
         tx_d.data = {2'b00, gen_sym.b};
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gen_lfsr_q <= PRBS_SEED;
         gen_idx_q  <= 9'h000;
         tx_q       <= '0;
      end else begin
         gen_lfsr_q <= gen_lfsr_d;
         gen_idx_q  <= gen_idx_d;
         tx_q       <= tx_d;
      end
   end

   // Verifier; sync comes from the channel word aligner
   always_comb begin
      v_state_d = v_state_q;
      v_exp_d   = v_exp_q;
      v_cnt_d   = v_cnt_q;
      v_idx_d   = v_idx_q;
      v_pass_d  = v_pass_q;
      set_done  = 1'b0;
      set_err   = 1'b0;
      unique case (v_state_q)
         VS_WAIT: begin
            if (rx_i.sync && v_prbs) begin
               v_exp_d   = prbs_step(rx_word, ctrl_wide_q);
               v_cnt_d   = 10'h001;
               v_state_d = VS_CHECK;
            end else if (rx_i.sync && v_inc) begin
               v_cnt_d   = 10'h000;
               v_state_d = VS_HUNT;
            end
         end
         VS_HUNT: begin
            if (rx_is_sof) begin
               v_idx_d   = INC_DATA0;
               v_pass_d  = 1'b0;
               v_state_d = VS_CHECK;
            end else if (v_cnt_q == 10'(SOF_WINDOW) - 10'h001) begin
               set_err   = 1'b1;
               set_done  = 1'b1;
               v_state_d = VS_DONE;
            end else begin
               v_cnt_d = v_cnt_q + 10'h001;
            end
         end
         VS_CHECK: begin
            if (v_prbs) begin
               if (!prbs_match) begin
                  set_err   = 1'b1;
                  v_state_d = VS_DONE;
               end else begin
                  v_exp_d = prbs_step(v_exp_q, ctrl_wide_q);
                  v_cnt_d = v_cnt_q + 10'h001;
                  if (v_cnt_q == prbs_total - 10'h001) begin
                     set_done  = 1'b1;
                     v_state_d = VS_DONE;
                  end
               end
            end else if (!inc_match) begin
               set_err   = 1'b1;
               set_done  = 1'b1;
               v_state_d = VS_DONE;
            end else if (v_idx_q == INC_LAST) begin
               // Second pass end completes the check
               v_idx_d  = 9'h000;
               v_pass_d = 1'b1;
               if (v_pass_q) begin
                  set_done  = 1'b1;
                  v_state_d = VS_DONE;
               end
            end else begin
               v_idx_d = v_idx_q + 9'h001;
            end
         end
         VS_DONE: v_state_d = VS_DONE;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         v_state_q <= VS_WAIT;
         v_exp_q   <= 10'h000;
         v_cnt_q   <= 10'h000;
         v_idx_q   <= 9'h000;
         v_pass_q  <= 1'b0;
      end else if (restart) begin
         v_state_q <= VS_WAIT;
         v_cnt_q   <= 10'h000;
         v_pass_q  <= 1'b0;
      end else begin
         v_state_q <= v_state_d;
         v_exp_q   <= v_exp_d;
         v_cnt_q   <= v_cnt_d;
         v_idx_q   <= v_idx_d;
         v_pass_q  <= v_pass_d;
      end
   end

   // Set beats restart so a final event is never lost
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         done_q   <= 1'b0;
         err_q    <= 1'b0;
         bypass_q <= 1'b0;
      end else begin
         done_q   <= (done_q && !restart) || set_done;
         err_q    <= (err_q && !restart) || set_err;
         bypass_q <= ctrl_prbs_q;
      end
   end

   assign reg_rdata_o     = rdata_q;
   assign tx_o            = tx_q;
   assign rx_dec_bypass_o = bypass_q;
   assign bist_done_o     = done_q;
   assign bist_err_o      = err_q;

   AST_PRBS8_STEP: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (ctrl_prbs_q && !ctrl_wide_q) ##1 (ctrl_prbs_q && !ctrl_wide_q)
      |=> tx_o.data == prbs_step($past(tx_o.data), 1'b0)
          && tx_o.data[9:8] == 2'b00)
      else $error("8-bit PRBS word does not follow polynomial");

   AST_PRBS10_STEP: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (ctrl_prbs_q && ctrl_wide_q) ##1 (ctrl_prbs_q && ctrl_wide_q)
      |=> tx_o.data == prbs_step($past(tx_o.data), 1'b1))
      else $error("10-bit PRBS word does not follow polynomial");

   AST_PRBS_BYPASS: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      ctrl_prbs_q |=> tx_o.enc_bypass && rx_dec_bypass_o && !tx_o.k)
      else $error("PRBS mode did not bypass the 8b/10b paths");

   AST_INC_WRAP: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (!ctrl_prbs_q && ctrl_mode_q == TM_INCR && tx_o.k
       && tx_o.data[7:0] == CH_K29_7) ##0
      (!ctrl_prbs_q && ctrl_mode_q == TM_INCR)[*2]
      |-> tx_o.k && tx_o.data[7:0] == CH_K28_5
          ##1 tx_o.k && tx_o.data[7:0] == CH_K27_7)
      else $error("Incremental sequence did not restart after EOF");

   AST_HF_CHAR: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (!ctrl_prbs_q && ctrl_mode_q == TM_HF)
      |=> !tx_o.k && tx_o.data == {2'b00, CH_D21_5}
          && tx_o.enc_bypass == $past(enc_off))
      else $error("High-frequency character or bypass wrong");

   AST_HF_RAW: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (!ctrl_prbs_q && ctrl_mode_q == TM_HF && enc_off)
      |=> tx_o.enc_bypass && tx_o.data[7:0] == CH_D21_5)
      else $error("High-frequency raw byte not sent unencoded");

   AST_LF_CHAR: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (!ctrl_prbs_q && ctrl_mode_q == TM_LF && ctrl_enc_q)
      |=> tx_o.k && !tx_o.enc_bypass && tx_o.data[7:0] == CH_K28_7)
      else $error("Low-frequency K28.7 not fed to encoder");

   AST_LF_RAW: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (!ctrl_prbs_q && ctrl_mode_q == TM_LF && enc_off)
      |=> tx_o.enc_bypass && tx_o.data == {2'b00, CH_K28_7})
      else $error("Low-frequency raw byte not sent unencoded");

   AST_MIX_CHAR: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (!ctrl_prbs_q && ctrl_mode_q == TM_MIX)
      |=> tx_o.k && tx_o.data == {2'b00, CH_K28_5})
      else $error("Mixed-frequency comma not generated");

   AST_NO_SYNC_NO_CHECK: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (v_state_q == VS_WAIT && !rx_i.sync)
      |=> v_state_q == VS_WAIT && !$rose(bist_err_o))
      else $error("Verifier left wait without word sync");

   AST_DONE_COUNT: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      ($rose(bist_done_o) && ctrl_prbs_q && $stable(ctrl_wide_q)
       && !$past(restart))
      |-> v_cnt_q == prbs_total && !bist_err_o)
      else $error("PRBS done raised before full sequence");

   AST_ERR_HOLD: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (bist_err_o && !restart) |=> bist_err_o)
      else $error("Error flag dropped without reset");

   AST_RESTART: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (restart && !set_done && !set_err)
      |=> !bist_done_o && !bist_err_o && v_state_q == VS_WAIT)
      else $error("Restart did not clear verifier");

   AST_SOF_WINDOW: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (v_state_q == VS_HUNT && !restart && !rx_is_sof
       && v_cnt_q == 10'h01E)
      |=> bist_err_o && bist_done_o)
      else $error("Missing SOF not flagged after 31 words");

endmodule

// *** tbg_loop.sv ***
`timescale 1ns/1ps
module tbg_loop (
   input  wire logic             clk_sys_i,
   input  wire tbg_pkg::tbg_tx_t tx_i,
   input  wire logic             sync_i,
   input  wire logic             slow_i,
   input  wire logic             flip_i,
   input  wire logic             kill_sof_i,
   output tbg_pkg::tbg_rx_t      rx_o
);
   import tbg_pkg::*;
   tbg_tx_t tx_q;
   tbg_tx_t tx_sel;
   logic    drop_sof;

   always_ff @(posedge clk_sys_i) begin
      tx_q <= tx_i;
   end

   // Slow path adds one word of loop delay
   assign tx_sel   = slow_i ? tx_q : tx_i;
   assign drop_sof = kill_sof_i && tx_sel.k && tx_sel.data[7:0] == CH_K27_7;

   always_comb begin
      rx_o.sync = sync_i;
      rx_o.k    = tx_sel.k;
      rx_o.data = tx_sel.data ^ {9'h000, flip_i};
      if (drop_sof) begin
         rx_o.data[7:0] = CH_K28_5;
      end
      // Unaligned words are garbage, not a copy of the stream
      if (!sync_i) begin
         rx_o.data = ~tx_sel.data;
      end
   end
endmodule

// *** test_tbg_bist.sv ***
`timescale 1ns/1ps
module test_tbg_bist;
   import tbg_pkg::*;
   logic        clk_sys_i          = 1'b0;
   logic        resetn_i           = 1'b0;
   logic [7:0]  reg_addr_i         = 8'h00;
   logic [31:0] reg_wdata_i        = 32'h0000_0000;
   logic        reg_wr_i           = 1'b0;
   logic        reg_rd_i           = 1'b0;
   logic        rx_digital_reset_i = 1'b0;
   logic [31:0] reg_rdata_o;
   tbg_tx_t     tx_o;
   tbg_rx_t     rx_i;
   logic        rx_dec_bypass_o;
   logic        bist_done_o;
   logic        bist_err_o;
   logic        sync = 1'b0;
   logic        slow = 1'b0;
   logic        flip = 1'b0;
   logic        kill = 1'b0;
   logic [31:0] seed = 32'h0000_9FC9;
   int          num_errors = 0;
   int          n_checks = 0;
   int          cyc = 0;

   always #50 clk_sys_i = ~clk_sys_i;

   tbg_bist DUT (
      .clk_sys_i          (clk_sys_i),
      .resetn_i           (resetn_i),
      .reg_addr_i         (reg_addr_i),
      .reg_wdata_i        (reg_wdata_i),
      .reg_wr_i           (reg_wr_i),
      .reg_rd_i           (reg_rd_i),
      .reg_rdata_o        (reg_rdata_o),
      .rx_digital_reset_i (rx_digital_reset_i),
      .tx_o               (tx_o),
      .rx_i               (rx_i),
      .rx_dec_bypass_o    (rx_dec_bypass_o),
      .bist_done_o        (bist_done_o),
      .bist_err_o         (bist_err_o)
   );

   tbg_loop u_loop (
      .clk_sys_i  (clk_sys_i),
      .tx_i       (tx_o),
      .sync_i     (sync),
      .slow_i     (slow),
      .flip_i     (flip),
      .kill_sof_i (kill),
      .rx_o       (rx_i)
   );

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 8000) begin
         num_errors++;
         report_and_stop();
      end
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic int lfsr(input int s, input bit w);
      int fb;
      fb = w ? (s >> 9) ^ (s >> 6) : (s >> 7) ^ (s >> 6) ^ (s >> 4) ^ (s >> 2);
      return ((s << 1) & (w ? 32'h0000_03FE : 32'h0000_00FE))
             | (fb & 32'h0000_0001);
   endfunction

   function automatic logic [8:0] inc_exp(input int i);
      logic [7:0] tail [10];
      tail = '{8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C,
               8'hDC, 8'hFC, 8'hF7, 8'hFE, 8'hFD};
      if (i == 0) return {1'b1, CH_K28_5};
      if (i == 1) return {1'b1, CH_K27_7};
      if (i < 258) return {1'b0, 8'(i - 2)};
      return {1'b1, tail[i - 258]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i   <= 1'b0;
      #1;
      d = reg_rdata_o;
   endtask

   task automatic wait_flags(input int lim, output int n);
      n = 0;
      while ((bist_done_o | bist_err_o) !== 1'b1 && n < lim) begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
   endtask

   task automatic pulse_rx_reset();
      @(posedge clk_sys_i);
      rx_digital_reset_i <= 1'b1;
      @(posedge clk_sys_i);
      rx_digital_reset_i <= 1'b0;
      #1;
   endtask

   // Each word must be the polynomial step of the one before
   task automatic run_gen(input bit w, input int n, input int fa);
      int first;
      int prev;
      int len;
      len = w ? 1023 : 255;
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys_i);
         flip <= (i == fa);
         #1;
         check(tx_o.enc_bypass, 1'b1);
         if (i > 0) check(tx_o.data, lfsr(prev, w));
         else first = tx_o.data;
         if (i == len) check(tx_o.data, first);
         if (i == 200 && fa < 0) check(bist_done_o, 1'b0);
         prev = tx_o.data;
      end
      flip <= 1'b0;
   endtask

   initial begin
      logic [31:0] d;
      logic [7:0]  a;
      logic [8:0]  eb;
      int          n;
      repeat (5) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      rd(ADDR_CTRL, d);
      check(d, CTRL_RESET);
      rd(ADDR_STAT, d);
      check(d, 32'h0000_0000);
      a = 8'(rnd());
      if (a == ADDR_CTRL || a == ADDR_STAT) a = 8'h08;
      wr(a, rnd());
      rd(a, d);
      check(d, 32'h0000_0000);
      rd(ADDR_CTRL, d);
      check(d, CTRL_RESET);
      for (int m = 0; m < 6; m++) begin
         for (int e = 0; e < 2 && m != 1; e++) begin
            wr(ADDR_CTRL, 32'(m << 1) | 32'(e << 4));
            @(posedge clk_sys_i);
            #1;
            eb = m == 2 ? {1'b0, CH_D21_5} : m == 3 ? {1'b1, CH_K28_7} :
                 m == 4 ? {1'b1, CH_K28_5} : 9'h000;
            check({tx_o.k, tx_o.data[7:0]}, eb);
            if (m > 1 && m < 5) check(tx_o.enc_bypass, e == 0);
            check(rx_dec_bypass_o, 1'b0);
         end
      end
      pulse_rx_reset();
      sync <= 1'b1;
      wr(ADDR_CTRL, 32'h0000_0012);
      for (int i = 0; i < 536; i++) begin
         @(posedge clk_sys_i);
         #1;
         check({tx_o.k, tx_o.data[7:0]}, inc_exp(i % 268));
         if (i == 300) check(bist_done_o, 1'b0);
      end
      wait_flags(100, n);
      check({bist_err_o, bist_done_o}, 2'b01);
      // Start of frame suppressed on the loop: hunt must give up
      kill <= 1'b1;
      wr(ADDR_CTRL, 32'h0000_0112);
      @(posedge clk_sys_i);
      #1;
      check({bist_err_o, bist_done_o}, 2'b00);
      wait_flags(60, n);
      check(n >= 28, 1'b1);
      check({bist_err_o, bist_done_o}, 2'b11);
      repeat (20) @(posedge clk_sys_i);
      check({bist_err_o, bist_done_o}, 2'b11);
      rd(ADDR_CTRL, d);
      check(d, 32'h0000_0012);
      kill <= 1'b0;
      // Mode off first so the generator restarts at the comma
      wr(ADDR_CTRL, CTRL_RESET);
      wr(ADDR_CTRL, 32'h0000_0112);
      repeat (40) @(posedge clk_sys_i);
      flip <= 1'b1;
      #1;
      check({bist_err_o, bist_done_o}, 2'b00);
      @(posedge clk_sys_i);
      flip <= 1'b0;
      wait_flags(10, n);
      check({bist_err_o, bist_done_o}, 2'b11);
      sync <= 1'b0;
      wr(ADDR_CTRL, 32'h0000_0111);
      repeat (2) @(posedge clk_sys_i);
      sync <= 1'b1;
      run_gen(1'b0, 260, -1);
      wait_flags(20, n);
      check({bist_err_o, bist_done_o}, 2'b01);
      check(rx_dec_bypass_o, 1'b1);
      rd(ADDR_STAT, d);
      check({d[25:16], d[3:0]}, {10'h0FF, 4'h9});
      sync <= 1'b0;
      slow <= 1'b1;
      wr(ADDR_CTRL, 32'h0000_0131);
      repeat (2) @(posedge clk_sys_i);
      sync <= 1'b1;
      run_gen(1'b1, 1030, 10 + int'(rnd() % 32'h0000_0258));
      check({bist_err_o, bist_done_o}, 2'b10);
      pulse_rx_reset();
      check({bist_err_o, bist_done_o}, 2'b00);
      wait_flags(1100, n);
      check({bist_err_o, bist_done_o}, 2'b01);
      rd(ADDR_STAT, d);
      check(d[25:16], 10'h3FF);
      report_and_stop();
   end
endmodule
